// ### dv/pfs_host.sv
`timescale 1ns/1ps
// Host model: one strobe per command, optional idle gap for a slow host
module pfs_host (
  input wire i_mclk,
  output logic o_wr,
  output logic o_rd,
  output logic [7:0] o_code,
  output logic [15:0] o_wdata
);
  // Idle port at time zero
  initial begin
    o_wr = 1'b0;
    o_rd = 1'b0;
    o_code = 8'h00;
    o_wdata = 16'h0000;
  end
  // Write when w is high, read otherwise; released data is inverted
  task automatic cmd(logic w, logic [7:0] c, logic [15:0] d, int gap);
    @(posedge i_mclk);
    o_wr <= w;
    o_rd <= !w;
    o_code <= c;
    o_wdata <= d;
    @(posedge i_mclk);
    o_wr <= 1'b0;
    o_rd <= 1'b0;
    o_code <= ~c;
    o_wdata <= ~d;
    repeat (gap) @(posedge i_mclk);
  endtask
endmodule // pfs_host

// ### dv/pfs_monitor.sv
`timescale 1ns/1ps
`include "pfs_regs.vh"
// Port checks on read answers, sequencing, power-good and alert
module pfs_monitor (
  input wire i_mclk,
  input wire i_rst,
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_vout_meas,
  input wire [15:0] i_vout_uv_level,
  input wire [15:0] o_cmd_rdata,
  input wire o_cmd_rvalid,
  input wire o_output_on,
  input wire o_ramp_up,
  input wire o_ramp_down,
  input wire o_power_good,
  input wire o_alert_n
);
  default clocking @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // Read answers
  a_read_answer: assert property (
    i_cmd_rd |=> o_cmd_rvalid) else $error("read unanswered");
  a_rdata_hold: assert property (
    !o_cmd_rvalid |-> $stable(o_cmd_rdata)) else $error("read data moved");
  // Sequencer outputs
  a_ramp_excl: assert property (
    !(o_ramp_up && o_ramp_down)) else $error("both ramps");
  a_rise_first: assert property (
    $rose(o_output_on) |-> o_ramp_up) else $error("on without rise");
  a_fall_powered: assert property (
    o_ramp_down |-> o_output_on) else $error("fall while off");
  // Power-good hysteresis
  a_good_drop: assert property (
    o_power_good && i_vout_meas < i_vout_uv_level |=> !o_power_good)
    else $error("good held low");
  a_good_rise: assert property (
    $rose(o_power_good) |-> $past(i_vout_meas) >= $past(i_vout_uv_level))
    else $error("good rose low");
  // Alert stays until the host clears it
  a_alert_hold: assert property (
    $rose(o_alert_n) |-> $past(i_cmd_wr, 2) &&
    $past(i_cmd_code, 2) == `PFS_CMD_CLEAR) else $error("alert dropped");
  a_refuse_flag: assert property (
    i_cmd_wr && i_cmd_code == `PFS_CMD_SUM_LOW && !$past(i_rst)
    |-> ##[1:2] !o_alert_n) else $error("refusal unflagged");
endmodule // pfs_monitor

bind pfs_top pfs_monitor u_mon (.i_mclk(i_mclk), .i_rst(i_rst),
  .i_cmd_wr(i_cmd_wr), .i_cmd_rd(i_cmd_rd), .i_cmd_code(i_cmd_code),
  .i_vout_meas(i_vout_meas), .i_vout_uv_level(i_vout_uv_level),
  .o_cmd_rdata(o_cmd_rdata), .o_cmd_rvalid(o_cmd_rvalid),
  .o_output_on(o_output_on), .o_ramp_up(o_ramp_up),
  .o_ramp_down(o_ramp_down), .o_power_good(o_power_good),
  .o_alert_n(o_alert_n));

// ### dv/pfs_top_tb.sv
`timescale 1ns/1ps
`include "pfs_regs.vh"
module pfs_top_tb;
  localparam int MS = 4;
  logic mclk, rst, wr, rd, wp, en, cold, bsy, oov, ooc;
  logic rvalid, out_on, r_up, r_dn, pg, alert_n;
  logic [7:0] code;
  logic [15:0] wdata, vin, vout, uvl, rdata;
  logic [15:0] s_lo = 16'hd1f4, s_vo = 16'h03e8, s_t1 = 16'h0001;
  logic [15:0] s_t2 = 16'h0002;
  logic [23:0] exp_q[$], head;
  int n_errors = 0, check_count = 0, cyc = 0, n, t;
  logic [7:0] cmds [16] = '{8'h78, 8'h79, 8'h7c, 8'h7e, 8'h54, 8'h55,
    8'h56, 8'h57, 8'h58, 8'h59, 8'h5a, 8'h5e, 8'h60, 8'h61, 8'h64, 8'h65};
  logic [15:0] dflt [16] = '{16'h0040, 16'h0840, 16'h0000, 16'h0000,
    16'h0080, 16'hd3a0, 16'h0080, 16'hd343, 16'hd226, 16'hd1f4, 16'h0080,
    16'h0384, 16'h0002, 16'h0002, 16'h0001, 16'h0002};

  pfs_top #(.MS_CYC(MS), .RETRY_CYC(20), .MS_PER_S(3)) dut (
    .i_mclk(mclk), .i_rst(rst), .i_cmd_wr(wr), .i_cmd_rd(rd),
    .i_cmd_code(code), .i_cmd_wdata(wdata), .o_cmd_rdata(rdata),
    .o_cmd_rvalid(rvalid), .i_write_protect(wp), .i_enable(en),
    .i_vin_meas(vin), .i_vout_meas(vout), .i_vout_uv_level(uvl),
    .i_cold_fault(cold), .i_busy_evt(bsy), .i_out_ov_evt(oov),
    .i_out_oc_evt(ooc), .i_strap_lo_flt(s_lo), .i_strap_vout(s_vo),
    .i_strap_ton_wait(s_t2), .i_strap_ton_ramp(s_t2),
    .i_strap_toff_wait(s_t1), .i_strap_toff_ramp(s_t2),
    .o_output_on(out_on), .o_ramp_up(r_up), .o_ramp_down(r_dn),
    .o_power_good(pg), .o_alert_n(alert_n));
  pfs_host host (.i_mclk(mclk), .o_wr(wr), .o_rd(rd), .o_code(code),
    .o_wdata(wdata));

  // Clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  task automatic chk(string nm, logic [15:0] got, logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic rdx(logic [7:0] c, logic [15:0] e);
    exp_q.push_back({c, e});
    host.cmd(1'b0, c, 16'h0000, 0);
  endtask
  task automatic wrc(logic [7:0] c, logic [15:0] d);
    host.cmd(1'b1, c, d, $urandom_range(2));
  endtask
  task automatic setv(logic [15:0] v);
    @(posedge mclk) vin <= v;
    repeat (3) @(posedge mclk);
  endtask
  task automatic wait_on(ref logic s, input logic v, output int k);
    k = 0;
    while (s !== v && k < 400) begin
      @(posedge mclk);
      #1;
      k++;
    end
  endtask
  task automatic tchk(string nm, int k, int lo);
    chk(nm, 16'(k >= lo - MS && k <= lo + 2 * MS), 16'h0001);
  endtask
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare each read answer with the oldest queued expectation
  always @(posedge mclk) begin
    if (rvalid === 1'b1) begin
      head = exp_q.size() ? exp_q.pop_front() : 24'hxxxxxx;
      chk($sformatf("cmd %h", head[23:16]), rdata, head[15:0]);
    end
  end
  // Hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 6000) begin
      n_errors++;
      give_verdict();
    end
  end

  // Main sequence
  initial begin
    rst = 1'b1;
    {wp, en, cold, bsy, oov, ooc} = 6'h00;
    vin = 16'hd300;
    vout = 16'h0000;
    uvl = 16'h0320;
    t = $urandom(66);
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
    repeat (2) @(posedge mclk);
    // Reset values, random write and read back, then restore
    foreach (cmds[i]) begin
      rdx(cmds[i], dflt[i]);
      if (i >= 4) begin
        t = $urandom();
        wrc(cmds[i], t[15:0]);
        rdx(cmds[i], t[15:0] & (dflt[i] == 16'h0080 ?
          16'h00ff : 16'hffff));
        wrc(cmds[i], dflt[i]);
      end
    end
    wrc(`PFS_CMD_CLEAR, 16'h0000);
    rdx(`PFS_CMD_SUM_FULL, 16'h0840);
    // Refused writes
    @(posedge mclk) wp <= 1'b1;
    wrc(`PFS_CMD_HI_WARN, 16'h1234);
    wrc(`PFS_CMD_SUM_LOW, 16'h00ff);
    rdx(`PFS_CMD_HI_WARN, `PFS_RST_HI_WARN);
    rdx(`PFS_CMD_COMM_STAT, 16'h0002);
    rdx(`PFS_CMD_SUM_LOW, 16'h0042);
    #1;
    chk("alert", {15'h0, alert_n}, 16'h0000);
    host.cmd(1'b1, `PFS_CMD_CLEAR, 16'h0000, 2);
    @(posedge mclk) wp <= 1'b0;
    #1;
    chk("alert", {15'h0, alert_n}, 16'h0001);
    // Input warnings and undervoltage hysteresis
    setv(16'hd352);
    setv(16'hd300);
    rdx(`PFS_CMD_SUM_FULL, 16'h2841);
    rdx(`PFS_CMD_IN_STAT, 16'h0040);
    wrc(`PFS_CMD_CLEAR, 16'h0000);
    setv(16'hd208);
    rdx(`PFS_CMD_IN_STAT, 16'h0020);
    setv(16'hd190);
    rdx(`PFS_CMD_SUM_LOW, 16'h0049);
    setv(16'hd212);
    wrc(`PFS_CMD_CLEAR, 16'h0000);
    rdx(`PFS_CMD_IN_STAT, 16'h0030);
    setv(16'hd258);
    wrc(`PFS_CMD_CLEAR, 16'h0000);
    rdx(`PFS_CMD_IN_STAT, 16'h0000);
    // Turn on, power good, turn off
    @(posedge mclk) en <= 1'b1;
    wait_on(r_up, 1'b1, n);
    tchk("turn on wait", n, 2 * MS);
    wait_on(r_up, 1'b0, n);
    tchk("rise time", n, 2 * MS);
    @(posedge mclk) vout <= 16'h03e8;
    repeat (3) @(posedge mclk);
    rdx(`PFS_CMD_SUM_FULL, 16'h0000);
    @(posedge mclk) en <= 1'b0;
    wait_on(r_dn, 1'b1, n);
    tchk("turn off wait", n, 3 * MS);
    wait_on(r_dn, 1'b0, n);
    tchk("fall time", n, 2 * MS);
    @(posedge mclk) vout <= 16'h0352;
    repeat (3) @(posedge mclk);
    #1;
    chk("good held", {15'h0, pg}, 16'h0001);
    @(posedge mclk) vout <= 16'h02ee;
    repeat (3) @(posedge mclk);
    rdx(`PFS_CMD_SUM_FULL, 16'h0840);
    // Stop without restart on a cold fault
    @(posedge mclk) en <= 1'b1;
    wait_on(out_on, 1'b1, n);
    @(posedge mclk) cold <= 1'b1;
    wait_on(out_on, 1'b0, n);
    chk("stop delay", 16'(n <= 4), 16'h0001);
    @(posedge mclk) cold <= 1'b0;
    repeat (60) @(posedge mclk);
    #1;
    chk("stopped", {15'h0, out_on}, 16'h0000);
    rdx(`PFS_CMD_SUM_LOW, 16'h0044);
    @(posedge mclk) en <= 1'b0;
    wrc(`PFS_CMD_CLEAR, 16'h0000);
    // Retry after input overvoltage, pause counted between attempts
    wrc(`PFS_CMD_HI_ACT, {8'h00, `PFS_ACT_RETRY});
    @(posedge mclk) en <= 1'b1;
    wait_on(out_on, 1'b1, n);
    setv(16'hd3b6);
    wait_on(out_on, 1'b0, n);
    repeat (28) @(posedge mclk);
    @(posedge mclk) vin <= 16'hd300;
    wait_on(out_on, 1'b1, n);
    tchk("retry restart", n, 18);
    rdx(`PFS_CMD_IN_STAT, 16'h00c0);
    @(posedge mclk) en <= 1'b0;
    wrc(`PFS_CMD_HI_ACT, {8'h00, `PFS_ACT_STOP});
    wrc(`PFS_CMD_CLEAR, 16'h0000);
    // Event bits in the summary
    @(posedge mclk) {bsy, oov, ooc} <= 3'b111;
    @(posedge mclk) {bsy, oov, ooc} <= 3'b000;
    repeat (40) @(posedge mclk);
    rdx(`PFS_CMD_SUM_FULL, 16'hc8f0);
    repeat (10) @(posedge mclk);
    chk("pending reads", 16'(exp_q.size()), 16'h0000);
    give_verdict();
  end
endmodule // pfs_top_tb

// ### hdl/pfs_regs.vh
`ifndef PFS_REGS_VH
`define PFS_REGS_VH
// Command codes
`define PFS_CMD_CLEAR 8'h03
`define PFS_CMD_COLD_ACT 8'h54
`define PFS_CMD_HI_FLT 8'h55
`define PFS_CMD_HI_ACT 8'h56
`define PFS_CMD_HI_WARN 8'h57
`define PFS_CMD_LO_WARN 8'h58
`define PFS_CMD_LO_FLT 8'h59
`define PFS_CMD_LO_ACT 8'h5a
`define PFS_CMD_GOOD 8'h5e
`define PFS_CMD_TON_WAIT 8'h60
`define PFS_CMD_TON_RAMP 8'h61
`define PFS_CMD_TOFF_WAIT 8'h64
`define PFS_CMD_TOFF_RAMP 8'h65
`define PFS_CMD_SUM_LOW 8'h78
`define PFS_CMD_SUM_FULL 8'h79
`define PFS_CMD_IN_STAT 8'h7c
`define PFS_CMD_COMM_STAT 8'h7e
// Reset values and action codes
`define PFS_ACT_STOP 8'h80
`define PFS_ACT_RETRY 8'hbf
`define PFS_RST_HI_FLT 16'hd3a0
`define PFS_RST_HI_WARN 16'hd343
// Summary bit positions
`define PFS_B_BUSY 7
`define PFS_B_OFF 6
`define PFS_B_OUT_OV 5
`define PFS_B_OUT_OC 4
`define PFS_B_IN_UV 3
`define PFS_B_TEMP 2
`define PFS_B_COMM 1
`define PFS_B_OTHER 0
`define PFS_B_VOUT 15
`define PFS_B_IOUT 14
`define PFS_B_INPUT 13
`define PFS_B_PG_N 11
// Input status bit positions
`define PFS_I_OV_F 7
`define PFS_I_OV_W 6
`define PFS_I_UV_W 5
`define PFS_I_UV_F 4
// Communication status bit for refused writes
`define PFS_C_WRPROT 1
// Timing
`define PFS_CLK_KHZ 200000
`define PFS_RETRY_MS 70
`define PFS_MS_PER_S 1000
`endif

// ### hdl/pfs_top.v
`timescale 1ns/1ps
`include "pfs_regs.vh"
// Overview of operation
// - Actions 80h stop, BFh retry every 70ms
// - Retry pause runs between restart attempts
// - Action bytes reset to 80h
// - Input overvoltage fault above 16-bit limit
// - Input undervoltage fault below strapped limit
// - Input high warning sets status, alerts host
// - Input low warning sets status, alerts host
// - Undervoltage fault clears above warning level
// - Low warning defaults to 1.1x fault strap
// - High warning protectable, resets to D343h
// - Power-good on above level, off below UV
// - Good level defaults to 0.9x output strap
// - Turn-on wait before output rise
// - Ramp output up over rise time
// - Turn-off wait in seconds before fall
// - Ramp output down over fall time
// - Summary byte bit map busy..other
// - Off bit whenever output unpowered
// - Status word upper byte bit map
// - Word low byte shares summary storage
// - Word bit 11 set while power-good low
// - Input status byte bits 7 to 4
// - Refused write sets communication bit 1
module pfs_top #(
  parameter MS_CYC = `PFS_CLK_KHZ, // Clock cycles in one millisecond
  parameter RETRY_CYC = `PFS_RETRY_MS * (`PFS_CLK_KHZ / 1000) * 1000,
  parameter MS_PER_S = `PFS_MS_PER_S
) (
  input wire i_mclk,
  input wire i_rst,
  input wire i_cmd_wr,
  input wire i_cmd_rd,
  input wire [7:0] i_cmd_code,
  input wire [15:0] i_cmd_wdata,
  output reg [15:0] o_cmd_rdata,
  output reg o_cmd_rvalid,
  input wire i_write_protect,
  input wire i_enable,
  input wire [15:0] i_vin_meas,
  input wire [15:0] i_vout_meas,
  input wire [15:0] i_vout_uv_level,
  input wire i_cold_fault,
  input wire i_busy_evt,
  input wire i_out_ov_evt,
  input wire i_out_oc_evt,
  input wire [15:0] i_strap_lo_flt,
  input wire [15:0] i_strap_vout,
  input wire [15:0] i_strap_ton_wait,
  input wire [15:0] i_strap_ton_ramp,
  input wire [15:0] i_strap_toff_wait,
  input wire [15:0] i_strap_toff_ramp,
  output reg o_output_on,
  output reg o_ramp_up,
  output reg o_ramp_down,
  output reg o_power_good,
  output reg o_alert_n
);

  // Sequencer states, one-hot
  localparam S_OFF = 8'h01;
  localparam S_TON_W = 8'h02;
  localparam S_RISE = 8'h04;
  localparam S_ON = 8'h08;
  localparam S_TOFF_W = 8'h10;
  localparam S_FALL = 8'h20;
  localparam S_HALT = 8'h40;
  localparam S_RETRY = 8'h80;

  // Linear-eleven value to signed fixed point, 8 fraction bits
  function signed [31:0] l11_fx;
    input [15:0] v;
    reg signed [31:0] m;
    reg signed [5:0] e;
    begin
      m = {{21{v[10]}}, v[10:0]};
      e = $signed({v[15], v[15:11]}) + 6'sd8;
      if (e[5])
        l11_fx = m >>> (-e);
      else
        l11_fx = m <<< e;
    end
  endfunction

  // Linear-eleven time to whole units, negatives clamp to zero
  function [31:0] l11_int;
    input [15:0] v;
    reg signed [31:0] f;
    begin
      f = l11_fx(v);
      if (f[31])
        l11_int = 32'h0;
      else
        l11_int = {8'h00, f[31:8]};
    end
  endfunction

  reg [7:0] cold_act_q, hi_act_q, lo_act_q;
  reg [15:0] hi_flt_q, hi_warn_q, lo_warn_q, lo_flt_q, good_q;
  reg [15:0] ton_wait_q, ton_ramp_q, toff_wait_q, toff_ramp_q;
  reg strap_ld_q;
  reg [7:0] state_q, state_d;
  reg [31:0] ms_div_q, cnt_q, tgt_d;
  reg cnt_clr;
  reg lo_flt_act_q;
  reg [3:0] in_stat_q;
  reg busy_q, out_ov_q, out_oc_q, temp_q, comm_q;
  wire [7:0] fault_act;
  wire ms_tick;
  wire hi_flt_now, hi_warn_now, lo_warn_now, lo_flt_now;
  wire any_fault;
  wire is_off;
  wire [7:0] sum_low;
  wire [15:0] sum_full;
  wire clr;
  wire [27:0] lo_warn_m, lo_warn_div;
  wire [19:0] good_m, good_div;

  // Millisecond enable pulse
  assign ms_tick = (ms_div_q == MS_CYC - 1);
  always @(posedge i_mclk) begin
    if (i_rst || ms_tick)
      ms_div_q <= 32'h0;
    else
      ms_div_q <= ms_div_q + 32'h1;
  end

  // Limit comparisons on input voltage
  assign hi_flt_now = l11_fx(i_vin_meas) > l11_fx(hi_flt_q);
  assign hi_warn_now = l11_fx(i_vin_meas) > l11_fx(hi_warn_q);
  assign lo_warn_now = l11_fx(i_vin_meas) < l11_fx(lo_warn_q);
  assign lo_flt_now = l11_fx(i_vin_meas) < l11_fx(lo_flt_q);

  // Undervoltage fault holds until input climbs over warning level
  always @(posedge i_mclk) begin
    if (i_rst)
      lo_flt_act_q <= 1'b0;
    else if (lo_flt_now)
      lo_flt_act_q <= 1'b1;
    else if (l11_fx(i_vin_meas) > l11_fx(lo_warn_q))
      lo_flt_act_q <= 1'b0;
  end

  // Strapped default scaling: low warning 1.1x, good level 0.9x
  assign lo_warn_m = {{17{i_strap_lo_flt[10]}}, i_strap_lo_flt[10:0]}
    * 28'sd11;
  assign good_m = {4'h0, i_strap_vout} * 20'd9;
  assign lo_warn_div = lo_warn_m / 28'd10;
  assign good_div = good_m / 20'd10;

  assign clr = i_cmd_wr && (i_cmd_code == `PFS_CMD_CLEAR);

  // Command register writes and strap capture after reset release
  always @(posedge i_mclk) begin
    if (i_rst) begin
      {cold_act_q, hi_act_q, lo_act_q} <= {3{`PFS_ACT_STOP}};
      {hi_flt_q, hi_warn_q} <= {`PFS_RST_HI_FLT, `PFS_RST_HI_WARN};
      {lo_warn_q, lo_flt_q, good_q} <= 48'h0;
      {ton_wait_q, ton_ramp_q, toff_wait_q, toff_ramp_q} <= 64'h0;
      strap_ld_q <= 1'b1;
    end else if (strap_ld_q) begin
      lo_flt_q <= i_strap_lo_flt;
      lo_warn_q <= {i_strap_lo_flt[15:11], lo_warn_div[10:0]};
      good_q <= good_div[15:0];
      ton_wait_q <= i_strap_ton_wait;
      ton_ramp_q <= i_strap_ton_ramp;
      toff_wait_q <= i_strap_toff_wait;
      toff_ramp_q <= i_strap_toff_ramp;
      strap_ld_q <= 1'b0;
    end else if (i_cmd_wr) begin
      case (i_cmd_code)
        `PFS_CMD_COLD_ACT: cold_act_q <= i_cmd_wdata[7:0];
        `PFS_CMD_HI_FLT: hi_flt_q <= i_cmd_wdata;
        `PFS_CMD_HI_ACT: hi_act_q <= i_cmd_wdata[7:0];
        `PFS_CMD_HI_WARN: begin
          if (!i_write_protect)
            hi_warn_q <= i_cmd_wdata;
        end
        `PFS_CMD_LO_WARN: lo_warn_q <= i_cmd_wdata;
        `PFS_CMD_LO_FLT: lo_flt_q <= i_cmd_wdata;
        `PFS_CMD_LO_ACT: lo_act_q <= i_cmd_wdata[7:0];
        `PFS_CMD_GOOD: good_q <= i_cmd_wdata;
        `PFS_CMD_TON_WAIT: ton_wait_q <= i_cmd_wdata;
        `PFS_CMD_TON_RAMP: ton_ramp_q <= i_cmd_wdata;
        `PFS_CMD_TOFF_WAIT: toff_wait_q <= i_cmd_wdata;
        `PFS_CMD_TOFF_RAMP: toff_ramp_q <= i_cmd_wdata;
        default: ;
      endcase
    end
  end

  // Sticky status bits; a new event wins over a clear
  always @(posedge i_mclk) begin
    if (i_rst) begin
      in_stat_q <= 4'h0;
      {busy_q, out_ov_q, out_oc_q, temp_q, comm_q} <= 5'h00;
    end else begin
      in_stat_q[`PFS_I_OV_F - 4] <= hi_flt_now
        | (in_stat_q[`PFS_I_OV_F - 4] & ~clr);
      in_stat_q[`PFS_I_OV_W - 4] <= hi_warn_now
        | (in_stat_q[`PFS_I_OV_W - 4] & ~clr);
      in_stat_q[`PFS_I_UV_W - 4] <= lo_warn_now
        | (in_stat_q[`PFS_I_UV_W - 4] & ~clr);
      in_stat_q[`PFS_I_UV_F - 4] <= lo_flt_act_q
        | (in_stat_q[`PFS_I_UV_F - 4] & ~clr);
      busy_q <= i_busy_evt | (busy_q & ~clr);
      out_ov_q <= i_out_ov_evt | (out_ov_q & ~clr);
      out_oc_q <= i_out_oc_evt | (out_oc_q & ~clr);
      temp_q <= i_cold_fault | (temp_q & ~clr);
      comm_q <= (i_cmd_wr && !strap_ld_q
        && ((i_cmd_code == `PFS_CMD_HI_WARN && i_write_protect)
        || i_cmd_code == `PFS_CMD_SUM_LOW
        || i_cmd_code == `PFS_CMD_SUM_FULL
        || i_cmd_code == `PFS_CMD_IN_STAT
        || i_cmd_code == `PFS_CMD_COMM_STAT))
        | (comm_q & ~clr);
    end
  end

  // Fault source picks the action byte; first match wins
  assign any_fault = hi_flt_now | lo_flt_act_q | i_cold_fault;
  assign fault_act = hi_flt_now ? hi_act_q
    : (lo_flt_act_q ? lo_act_q : cold_act_q);

  // Sequencer next state and timer targets in ms or cycles
  always @* begin
    state_d = state_q;
    cnt_clr = 1'b0;
    case (state_q)
      S_TON_W: tgt_d = l11_int(ton_wait_q);
      S_RISE: tgt_d = l11_int(ton_ramp_q);
      S_TOFF_W: tgt_d = l11_int(toff_wait_q) * MS_PER_S;
      S_FALL: tgt_d = l11_int(toff_ramp_q);
      S_RETRY: tgt_d = RETRY_CYC - 1;
      default: tgt_d = 32'h0;
    endcase
    if (any_fault && (state_q & (S_TON_W | S_RISE | S_ON
        | S_TOFF_W | S_FALL)) != 8'h00) begin
      cnt_clr = 1'b1;
      if (fault_act == `PFS_ACT_RETRY)
        state_d = S_RETRY;
      else
        state_d = S_HALT;
    end else begin
      case (state_q)
        S_OFF: begin
          if (i_enable && !any_fault) begin
            state_d = S_TON_W;
            cnt_clr = 1'b1;
          end
        end
        S_TON_W: begin
          if (!i_enable) begin
            state_d = S_OFF;
            cnt_clr = 1'b1;
          end else if (cnt_q >= tgt_d) begin
            state_d = S_RISE;
            cnt_clr = 1'b1;
          end
        end
        S_RISE: begin
          if (cnt_q >= tgt_d) begin
            state_d = S_ON;
            cnt_clr = 1'b1;
          end
        end
        S_ON: begin
          if (!i_enable) begin
            state_d = S_TOFF_W;
            cnt_clr = 1'b1;
          end
        end
        S_TOFF_W: begin
          if (i_enable) begin
            state_d = S_ON;
            cnt_clr = 1'b1;
          end else if (cnt_q >= tgt_d) begin
            state_d = S_FALL;
            cnt_clr = 1'b1;
          end
        end
        S_FALL: begin
          if (cnt_q >= tgt_d) begin
            state_d = S_OFF;
            cnt_clr = 1'b1;
          end
        end
        S_HALT: begin
          if (!i_enable) begin
            state_d = S_OFF;
            cnt_clr = 1'b1;
          end
        end
        S_RETRY: begin
          if (!i_enable) begin
            state_d = S_OFF;
            cnt_clr = 1'b1;
          end else if (cnt_q >= tgt_d) begin
            cnt_clr = 1'b1;
            if (!any_fault)
              state_d = S_TON_W;
          end
        end
        default: begin
          state_d = S_OFF;
          cnt_clr = 1'b1;
        end
      endcase
    end
  end

  // Sequencer state and timer; retry counts cycles, others ms
  always @(posedge i_mclk) begin
    if (i_rst) begin
      state_q <= S_OFF;
      cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (cnt_clr)
        cnt_q <= 32'h0;
      else if (state_q == S_RETRY || ms_tick)
        cnt_q <= cnt_q + 32'h1;
    end
  end

  // Power-good with hysteresis on output voltage
  always @(posedge i_mclk) begin
    if (i_rst)
      o_power_good <= 1'b0;
    else if (i_vout_meas < i_vout_uv_level)
      o_power_good <= 1'b0;
    else if (i_vout_meas > good_q)
      o_power_good <= 1'b1;
  end

  // Off whenever output is not being driven
  assign is_off = (state_q & (S_RISE | S_ON | S_TOFF_W | S_FALL))
    == 8'h00;

  assign sum_low = {busy_q, is_off, out_ov_q, out_oc_q,
    in_stat_q[`PFS_I_UV_F - 4], temp_q, comm_q,
    in_stat_q[`PFS_I_OV_F - 4] | in_stat_q[`PFS_I_OV_W - 4]
    | in_stat_q[`PFS_I_UV_W - 4]};
  assign sum_full = {out_ov_q, out_oc_q, |in_stat_q, 1'b0,
    ~o_power_good, 3'b000, sum_low};

  // Sequencer outputs and host alert
  always @(posedge i_mclk) begin
    if (i_rst) begin
      {o_output_on, o_ramp_up, o_ramp_down} <= 3'b000;
      o_alert_n <= 1'b1;
    end else begin
      o_output_on <= (state_d & (S_RISE | S_ON | S_TOFF_W | S_FALL))
        != 8'h00;
      o_ramp_up <= state_d == S_RISE;
      o_ramp_down <= state_d == S_FALL;
      o_alert_n <= ~(|in_stat_q | busy_q | out_ov_q | out_oc_q
        | temp_q | comm_q);
    end
  end

  // Read port: data one cycle after the read strobe
  always @(posedge i_mclk) begin
    if (i_rst) begin
      {o_cmd_rdata, o_cmd_rvalid} <= 17'h00000;
    end else begin
      o_cmd_rvalid <= i_cmd_rd;
      if (i_cmd_rd) begin
        case (i_cmd_code)
          `PFS_CMD_COLD_ACT: o_cmd_rdata <= {8'h00, cold_act_q};
          `PFS_CMD_HI_FLT: o_cmd_rdata <= hi_flt_q;
          `PFS_CMD_HI_ACT: o_cmd_rdata <= {8'h00, hi_act_q};
          `PFS_CMD_HI_WARN: o_cmd_rdata <= hi_warn_q;
          `PFS_CMD_LO_WARN: o_cmd_rdata <= lo_warn_q;
          `PFS_CMD_LO_FLT: o_cmd_rdata <= lo_flt_q;
          `PFS_CMD_LO_ACT: o_cmd_rdata <= {8'h00, lo_act_q};
          `PFS_CMD_GOOD: o_cmd_rdata <= good_q;
          `PFS_CMD_TON_WAIT: o_cmd_rdata <= ton_wait_q;
          `PFS_CMD_TON_RAMP: o_cmd_rdata <= ton_ramp_q;
          `PFS_CMD_TOFF_WAIT: o_cmd_rdata <= toff_wait_q;
          `PFS_CMD_TOFF_RAMP: o_cmd_rdata <= toff_ramp_q;
          `PFS_CMD_SUM_LOW: o_cmd_rdata <= {8'h00, sum_low};
          `PFS_CMD_SUM_FULL: o_cmd_rdata <= sum_full;
          `PFS_CMD_IN_STAT: o_cmd_rdata <= {8'h00, in_stat_q, 4'h0};
          `PFS_CMD_COMM_STAT: o_cmd_rdata <= {14'h0000, comm_q, 1'b0};
          default: o_cmd_rdata <= 16'h0000;
        endcase
      end
    end
  end

endmodule // pfs_top
